// file: hdl/vof_consts.svh
`ifndef VOF_CONSTS_SVH
`define VOF_CONSTS_SVH
// ---------------------------------------------------------------
// Subaddresses and register reset value
// ---------------------------------------------------------------
`define VF_A_MODE  8'h01
`define VF_A_OUTC  8'h02
`define VF_A_TSTD  8'h30
`define VF_A_TPG   8'h31
`define VF_A_HDF   8'h33
`define VF_A_HDIN  8'h35
`define VF_A_COLA  8'h36
`define VF_A_COLB  8'h37
`define VF_A_COLC  8'h38
`define VF_A_SDF   8'h80
`define VF_A_SDM   8'h82
`define VF_A_SDM4  8'h87
`define VF_A_GAIN  8'hA2
`define VF_RST     8'h00
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define VF_MODE_HI 6
`define VF_MODE_LO 4
`define VF_YPRPB   5
`define VF_TPG_EN  2
`define VF_TPG_UNI 3
`define VF_SINC_OFF 3
`define VF_HD_CFLAT 1
`define VF_HD_C444 0
`define VF_HD_RGB  1
`define VF_SQ_EN   4
`define VF_CD_FLAT 0
`define VF_SD_RGB  7
`define VF_GAIN_EN 4
`define VF_SD_PAL  0
`define VF_LUMA_HI 4
`define VF_LUMA_LO 2
`define VF_CHR_HI  7
`define VF_CHR_LO  5
// ---------------------------------------------------------------
// Values and counts
// ---------------------------------------------------------------
`define VF_GAIN_MAX 4'hC
`define VF_GAIN_BASE 8'h28
`define VF_GAIN_STEP 8'h05
`define VF_PIX_NTSC 10'h35A
`define VF_PIX_NTSC_SQ 10'h30C
`define VF_PIX_PAL 10'h360
`define VF_PIX_PAL_SQ 10'h3B0
`define VF_LN_NTSC 10'h20D
`define VF_LN_PAL  10'h271
`define VF_BLACK   8'h10
`define VF_MID     8'h80
`define VF_TAPS_CFLAT 15'h0866
`endif

// file: hdl/vof_pkg.sv
package vof_pkg;
   typedef logic [7:0] pix_t;
   typedef enum logic [2:0] {
      L_LPF_N = 3'h0, L_LPF_P = 3'h1, L_NOTCH_N = 3'h2, L_NOTCH_P = 3'h3,
      L_FLAT = 3'h4, L_CIF = 3'h5, L_QCIF = 3'h6, L_RSV = 3'h7
   } luma_sel_t;
endpackage

// file: hdl/video_output_filter_colorspace.sv
// Summary of operation
// - Subaddress 0x82 bit 4 set enters standard-definition square pixel operation.
// - Square pixel operation switches line timing to square-pixel counts.
// - Luma filter chosen by 0x80 bits 4:2: lowpass, notch, extended-flat, CIF, QCIF.
// - Chroma filter offers five lowpass responses plus CIF and QCIF.
// - Extended-flat luma gain enabled by 0x87 bit 4; 13 steps chosen by 0xA2.
// - Dedicated extended-flat filter serves the Pr and Pb outputs.
// - Subaddress 0x82 bit 0 enables the color-difference extended-flat filter.
// - Enabled or not, selected chroma filter feeds composite and luma/chroma outputs.
// - Luma cutoffs: NTSC lowpass, PAL lowpass and extended-flat differ.
// - Sinc compensation acts on the first three DAC outputs in ED/HD, on the first only when 0x33 bit 1 selects the flat chroma filter.
// - Sinc compensation is on after reset; 0x33 bit 3 bypasses it.
// - Test pattern takes its color from 0x36..0x38 in ED/HD when 0x31 bit 2 is set.
// - Test pattern color registers never touch external pixel data.
// - Conversion is chosen from input mode 0x01 bits 6:4 and color selects.
// - RGB to YPrPb conversion exists in SD only, never in ED/HD.
// - 0x02 bit 5 high gives YPrPb component output, low gives RGB; ED/HD RGB input gives RGB either way.
// - In SD, 0x87 bit 7 marks input pixels as RGB, else YCrCb.
// - In ED/HD, 0x35 bit 1 marks input as RGB; RGB input gives RGB output.
// - Composite and luma/chroma outputs stay available for every SD combination.
// - 0x33 selects ED/HD chroma input, sinc and chroma filter; 0x82 SD filter.
`timescale 1ns/10ps
`include "vof_consts.svh"

module vof_fifo #(
   parameter int W = 24,
   parameter int DEPTH = 32
) (
   input  wire logic         mclk,
   input  wire logic         sys_rst,
   // Fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0]   cnt_r;
   logic          push;
   logic          pop;

   assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem[rp_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wp_r] <= in_data;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

module video_output_filter_colorspace #(
   parameter int FIFO_DEPTH = 32
) (
   input  wire logic          mclk,
   input  wire logic          sys_rst,
   // Subaddressed register port
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   input  wire logic [7:0]    reg_addr,
   input  wire logic [7:0]    reg_wdata,
   output logic [7:0]         reg_rdata,
   // Pixel input (Y/G, Cb/B, Cr/R)
   input  wire logic          pix_valid,
   output logic               pix_ready,
   input  wire vof_pkg::pix_t pix_a,
   input  wire vof_pkg::pix_t pix_b,
   input  wire vof_pkg::pix_t pix_c,
   // Video outputs
   output logic               out_valid,
   input  wire logic          out_ready,
   output vof_pkg::pix_t      dac1,
   output vof_pkg::pix_t      dac2,
   output vof_pkg::pix_t      dac3,
   output vof_pkg::pix_t      luma_out,
   output vof_pkg::pix_t      chroma_out,
   output vof_pkg::pix_t      composite_output,
   // Timing state
   output logic [9:0]         pix_count,
   output logic [9:0]         line_count,
   output logic               square_active
);
   import vof_pkg::*;

   // ---------------------------------------------------------------
   // Arithmetic helpers
   // ---------------------------------------------------------------
   function automatic pix_t sat8(input logic signed [19:0] v);
      sat8 = (v < 20'sh00000) ? 8'h00 : (v > 20'sh000FF) ? 8'hFF : v[7:0];
   endfunction

   function automatic logic signed [19:0] sx(input pix_t p);
      sx = {12'h000, p};
   endfunction

   // Taps {outer, inner, centre}, with 2*outer + 2*inner + centre = 16
   function automatic pix_t fir(input logic [39:0] w, input logic [14:0] t);
      logic [12:0] s;
      s = 13'(t[14:10]) * (13'(w[39:32]) + 13'(w[7:0]))
        + 13'(t[9:5]) * (13'(w[31:24]) + 13'(w[15:8]))
        + 13'(t[4:0]) * 13'(w[23:16]);
      fir = s[11:4];
   endfunction

   function automatic logic [14:0] luma_taps(input luma_sel_t s);
      case (s)
         L_LPF_N:   luma_taps = {5'h02, 5'h04, 5'h04};
         L_LPF_P:   luma_taps = {5'h01, 5'h04, 5'h06};
         L_NOTCH_N: luma_taps = {5'h04, 5'h00, 5'h08};
         L_NOTCH_P: luma_taps = {5'h03, 5'h01, 5'h08};
         L_CIF:     luma_taps = {5'h03, 5'h04, 5'h02};
         L_QCIF:    luma_taps = {5'h04, 5'h04, 5'h00};
         default:   luma_taps = {5'h00, 5'h00, 5'h10};
      endcase
   endfunction

   function automatic logic [14:0] chroma_taps(input logic [2:0] s);
      case (s)
         3'h0:    chroma_taps = {5'h02, 5'h04, 5'h04};
         3'h1:    chroma_taps = {5'h04, 5'h04, 5'h00};
         3'h2:    chroma_taps = {5'h03, 5'h04, 5'h02};
         3'h3:    chroma_taps = {5'h01, 5'h04, 5'h06};
         3'h4:    chroma_taps = {5'h00, 5'h04, 5'h08};
         3'h5:    chroma_taps = {5'h01, 5'h02, 5'h0A};
         3'h6:    chroma_taps = {5'h04, 5'h03, 5'h02};
         default: chroma_taps = {5'h04, 5'h04, 5'h00};
      endcase
   endfunction

   // Peaking that lifts the top of the band lost to the DAC hold
   function automatic pix_t sinc(input logic [39:0] w);
      logic signed [19:0] c;
      c = sx(w[23:16]);
      sinc = sat8(c + ((20'sh00002 * c - sx(w[31:24]) - sx(w[15:8])) >>> 3));
   endfunction

   function automatic logic [23:0] rgb2ycc(input pix_t r, input pix_t g, input pix_t b);
      logic signed [19:0] y;
      logic signed [19:0] cb;
      logic signed [19:0] cr;
      y  = ((20'sh00042 * sx(r) + 20'sh00081 * sx(g) + 20'sh00019 * sx(b)
           + 20'sh00080) >>> 8) + 20'sh00010;
      cb = ((20'sh00070 * sx(b) - 20'sh00026 * sx(r) - 20'sh0004A * sx(g)
           + 20'sh00080) >>> 8) + 20'sh00080;
      cr = ((20'sh00070 * sx(r) - 20'sh0005E * sx(g) - 20'sh00012 * sx(b)
           + 20'sh00080) >>> 8) + 20'sh00080;
      rgb2ycc = {sat8(y), sat8(cb), sat8(cr)};
   endfunction

   function automatic logic [23:0] ycc2rgb(input pix_t y, input pix_t cb, input pix_t cr);
      logic signed [19:0] c;
      logic signed [19:0] d;
      logic signed [19:0] e;
      c = 20'sh0012A * (sx(y) - 20'sh00010);
      d = sx(cb) - 20'sh00080;
      e = sx(cr) - 20'sh00080;
      ycc2rgb = {sat8((c - 20'sh00064 * d - 20'sh000D0 * e + 20'sh00080) >>> 8),
                 sat8((c + 20'sh00204 * d + 20'sh00080) >>> 8),
                 sat8((c + 20'sh00199 * e + 20'sh00080) >>> 8)};
   endfunction

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   pix_t mode_r, outc_r, tstd_r, tpg_r, hdf_r, hdin_r;
   pix_t cola_r, colb_r, colc_r, sdf_r, sdm_r, sdm4_r, gain_r;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         mode_r <= `VF_RST;
         outc_r <= `VF_RST;
         tstd_r <= `VF_RST;
         tpg_r  <= `VF_RST;
         hdf_r  <= `VF_RST;
         hdin_r <= `VF_RST;
         cola_r <= `VF_RST;
         colb_r <= `VF_RST;
         colc_r <= `VF_RST;
         sdf_r  <= `VF_RST;
         sdm_r  <= `VF_RST;
         sdm4_r <= `VF_RST;
         gain_r <= `VF_RST;
      end else if (reg_wr) begin
         if (reg_addr == `VF_A_MODE) begin
            mode_r <= reg_wdata;
         end else if (reg_addr == `VF_A_OUTC) begin
            outc_r <= reg_wdata;
         end else if (reg_addr == `VF_A_TSTD) begin
            tstd_r <= reg_wdata;
         end else if (reg_addr == `VF_A_TPG) begin
            tpg_r <= reg_wdata;
         end else if (reg_addr == `VF_A_HDF) begin
            hdf_r <= reg_wdata;
         end else if (reg_addr == `VF_A_HDIN) begin
            hdin_r <= reg_wdata;
         end else if (reg_addr == `VF_A_COLA) begin
            cola_r <= reg_wdata;
         end else if (reg_addr == `VF_A_COLB) begin
            colb_r <= reg_wdata;
         end else if (reg_addr == `VF_A_COLC) begin
            colc_r <= reg_wdata;
         end else if (reg_addr == `VF_A_SDF) begin
            sdf_r <= reg_wdata;
         end else if (reg_addr == `VF_A_SDM) begin
            sdm_r <= reg_wdata;
         end else if (reg_addr == `VF_A_SDM4) begin
            sdm4_r <= reg_wdata;
         end else if (reg_addr == `VF_A_GAIN) begin
            gain_r <= reg_wdata;
         end
      end
   end

   // Unmapped subaddresses read as zero
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (reg_addr == `VF_A_MODE) reg_rdata <= mode_r;
         else if (reg_addr == `VF_A_OUTC) reg_rdata <= outc_r;
         else if (reg_addr == `VF_A_TSTD) reg_rdata <= tstd_r;
         else if (reg_addr == `VF_A_TPG) reg_rdata <= tpg_r;
         else if (reg_addr == `VF_A_HDF) reg_rdata <= hdf_r;
         else if (reg_addr == `VF_A_HDIN) reg_rdata <= hdin_r;
         else if (reg_addr == `VF_A_COLA) reg_rdata <= cola_r;
         else if (reg_addr == `VF_A_COLB) reg_rdata <= colb_r;
         else if (reg_addr == `VF_A_COLC) reg_rdata <= colc_r;
         else if (reg_addr == `VF_A_SDF) reg_rdata <= sdf_r;
         else if (reg_addr == `VF_A_SDM) reg_rdata <= sdm_r;
         else if (reg_addr == `VF_A_SDM4) reg_rdata <= sdm4_r;
         else if (reg_addr == `VF_A_GAIN) reg_rdata <= gain_r;
         else reg_rdata <= 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // Mode decode
   // ---------------------------------------------------------------
   logic sd, pal, sq, in_rgb, hd_pass, out_rgb, tp_on, sinc_on;
   luma_sel_t lsel;
   logic [3:0] gsel;

   assign sd      = (mode_r[`VF_MODE_HI:`VF_MODE_LO] == 3'h0);
   assign pal     = sdf_r[`VF_SD_PAL];
   assign sq      = sd & sdm_r[`VF_SQ_EN];
   assign in_rgb  = sd ? sdm4_r[`VF_SD_RGB] : hdin_r[`VF_HD_RGB];
   assign hd_pass = ~sd & hdin_r[`VF_HD_RGB];
   assign out_rgb = ~outc_r[`VF_YPRPB] | hd_pass;
   assign tp_on   = ~sd & tpg_r[`VF_TPG_EN];
   assign sinc_on = ~hdf_r[`VF_SINC_OFF];
   assign lsel    = luma_sel_t'(sdf_r[`VF_LUMA_HI:`VF_LUMA_LO]);
   assign gsel    = (gain_r[3:0] > `VF_GAIN_MAX) ? `VF_GAIN_MAX : gain_r[3:0];
   assign square_active = sq;

   // ---------------------------------------------------------------
   // Input buffer and stall
   // ---------------------------------------------------------------
   logic        f_valid;
   logic [23:0] f_data;
   logic        en;
   logic        take;

   // Whole pipeline halts while the output is held, so the FIFO fills
   assign en   = out_ready | ~out_valid;
   assign take = f_valid & en;

   vof_fifo #(.W(24), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .in_valid  (pix_valid),
      .in_ready  (pix_ready),
      .in_data   ({pix_a, pix_b, pix_c}),
      .out_valid (f_valid),
      .out_ready (en),
      .out_data  (f_data)
   );

   // ---------------------------------------------------------------
   // Line and pixel timing
   // ---------------------------------------------------------------
   logic [9:0] pix_total;
   logic [9:0] line_total;

   // Only the square pixel, SD mode (0x01 bits 6:4) and PAL bits change the counts; filter selects never do
   assign pix_total = sq ? (pal ? `VF_PIX_PAL_SQ : `VF_PIX_NTSC_SQ)
                         : (pal ? `VF_PIX_PAL : `VF_PIX_NTSC);
   assign line_total = pal ? `VF_LN_PAL : `VF_LN_NTSC;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pix_count  <= '0;
         line_count <= '0;
      end else if (take) begin
         if (pix_count >= pix_total - 10'h001) begin
            pix_count  <= '0;
            line_count <= (line_count >= line_total - 10'h001) ? '0 : line_count + 10'h001;
         end else begin
            pix_count <= pix_count + 10'h001;
         end
      end
   end

   // ---------------------------------------------------------------
   // Source select and input conversion
   // ---------------------------------------------------------------
   logic [23:0] src;
   logic [23:0] ycc;
   logic [39:0] wy_r, wb_r, wr_r;
   pix_t cb_new, cr_new;

   always_comb begin
      if (tp_on) begin
         // Colour registers only ever reach the generated pattern
         if (tpg_r[`VF_TPG_UNI] || pix_count[4:0] == 5'h00 || line_count[4:0] == 5'h00) begin
            src = {cola_r, colc_r, colb_r};
         end else begin
            src = {`VF_BLACK, `VF_MID, `VF_MID};
         end
         ycc = src;
      end else begin
         src = f_data;
         ycc = (in_rgb & sd) ? rgb2ycc(f_data[7:0], f_data[23:16], f_data[15:8])
                             : f_data;
      end
      // 4:2:2 chroma input holds the chroma of the even sample
      if (~sd & ~hdf_r[`VF_HD_C444] & pix_count[0]) begin
         cb_new = wb_r[7:0];
         cr_new = wr_r[7:0];
      end else begin
         cb_new = ycc[15:8];
         cr_new = ycc[7:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         wy_r <= '0;
         wb_r <= '0;
         wr_r <= '0;
      end else if (take) begin
         wy_r <= {wy_r[31:0], ycc[23:16]};
         wb_r <= {wb_r[31:0], cb_new};
         wr_r <= {wr_r[31:0], cr_new};
      end
   end

   // ---------------------------------------------------------------
   // Filters and output conversion
   // ---------------------------------------------------------------
   pix_t y_f, cb_c, cr_c, cb_f, cr_f, y_g;
   logic [14:0] gprod;
   logic [23:0] comp;
   logic        v1_r;

   always_comb begin
      y_g   = fir(wy_r, luma_taps(lsel));
      gprod = 15'(y_g) * 15'(`VF_GAIN_BASE + `VF_GAIN_STEP * 8'(gsel));
      cb_c  = fir(wb_r, chroma_taps(sdf_r[`VF_CHR_HI:`VF_CHR_LO]));
      cr_c  = fir(wr_r, chroma_taps(sdf_r[`VF_CHR_HI:`VF_CHR_LO]));
      if (sd) begin
         if (lsel == L_FLAT && sdm4_r[`VF_GAIN_EN]) begin
            y_f = gprod[14] ? 8'hFF : gprod[13:6];
         end else begin
            y_f = y_g;
         end
         if (sdm_r[`VF_CD_FLAT]) begin
            cb_f = fir(wb_r, `VF_TAPS_CFLAT);
            cr_f = fir(wr_r, `VF_TAPS_CFLAT);
         end else begin
            cb_f = cb_c;
            cr_f = cr_c;
         end
      end else begin
         y_f = sinc_on ? sinc(wy_r) : wy_r[23:16];
         if (hdf_r[`VF_HD_CFLAT]) begin
            cb_f = fir(wb_r, `VF_TAPS_CFLAT);
            cr_f = fir(wr_r, `VF_TAPS_CFLAT);
         end else begin
            cb_f = sinc_on ? sinc(wb_r) : wb_r[23:16];
            cr_f = sinc_on ? sinc(wr_r) : wr_r[23:16];
         end
      end
      // Pass-through RGB already sits as G, B, R in the three lanes
      if (out_rgb & ~hd_pass) begin
         comp = ycc2rgb(y_f, cb_f, cr_f);
      end else begin
         comp = {y_f, cb_f, cr_f};
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         v1_r      <= 1'b0;
         out_valid <= 1'b0;
      end else if (en) begin
         v1_r      <= f_valid;
         out_valid <= v1_r;
      end
   end

   // Composite and Y/C come from the selected chroma filter in every
   // SD colour space combination; subcarrier modulation lives elsewhere
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         dac1             <= 8'h00;
         dac2             <= 8'h00;
         dac3             <= 8'h00;
         luma_out         <= 8'h00;
         chroma_out       <= `VF_MID;
         composite_output <= 8'h00;
      end else if (en) begin
         dac1       <= comp[23:16];
         dac2       <= comp[15:8];
         dac3       <= comp[7:0];
         luma_out   <= y_f;
         chroma_out <= pix_count[0] ? cr_c : cb_c;
         composite_output <= sat8(sx(y_f) + sx(pix_count[0] ? cr_c : cb_c)
                                  - 20'sh00080);
      end
   end
endmodule

// file: tb/vof_props.sv
`timescale 1ns/10ps
// ---------------------------------------------
// Port checks
// ---------------------------------------------
module vof_props (
   // Clock, reset
   input wire logic          mclk,
   input wire logic          sys_rst,
   // Registers
   input wire logic          reg_wr,
   input wire logic          reg_rd,
   input wire logic [7:0]    reg_addr,
   input wire logic [7:0]    reg_wdata,
   input wire logic [7:0]    reg_rdata,
   // Stream, timing
   input wire logic          pix_ready,
   input wire logic          out_valid,
   input wire logic          out_ready,
   input wire vof_pkg::pix_t dac1,
   input wire vof_pkg::pix_t chroma_out,
   input wire logic [9:0]    pix_count,
   input wire logic [9:0]    line_count,
   input wire logic          square_active
);
   import vof_pkg::*;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   logic [7:0] shadow_r [256];
   logic [7:0] exp_r;
   logic       mapped;
   assign mapped = reg_addr inside {8'h01, 8'h02, 8'h30, 8'h31, 8'h33, 8'h35, 8'h36,
                                    8'h37, 8'h38, 8'h80, 8'h82, 8'h87, 8'hA2};
   // Shadow takes writes on the same edge as the block does
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         for (int i = 0; i < 256; i++)
            shadow_r[i] <= 8'h00;
      end else if (reg_wr) begin
         shadow_r[reg_addr] <= reg_wdata;
      end
   end
   always_ff @(posedge mclk) begin
      exp_r <= shadow_r[reg_addr];
   end
   property p_rst;
      disable iff (1'b0) sys_rst |=> reg_rdata == 8'h00 && !out_valid && pix_ready
         && chroma_out == 8'h80 && pix_count == 10'h000 && line_count == 10'h000;
   endproperty
   property p_rdback;
      reg_rd && !reg_wr && reg_addr inside {8'h36, 8'h37, 8'h38} |=> reg_rdata == exp_r;
   endproperty
   property p_unmap;
      reg_rd && !mapped |=> reg_rdata == 8'h00;
   endproperty
   property p_rdhold;
      !reg_rd |=> $stable(reg_rdata);
   endproperty
   property p_hold;
      out_valid && !out_ready |=> out_valid && $stable(dac1) && $stable(chroma_out);
   endproperty
   property p_square;
      square_active == (shadow_r[8'h01][6:4] == 3'h0 && shadow_r[8'h82][4]);
   endproperty
   property p_step;
      $changed(pix_count) |-> pix_count == $past(pix_count) + 10'h001 || pix_count == 10'h000;
   endproperty
   property p_line;
      $changed(line_count) |-> pix_count == 10'h000;
   endproperty
   property p_max;
      pix_count < 10'h3B0 && line_count < 10'h271;
   endproperty
   a_rst: assert property (p_rst) else $error("reset values wrong");
   a_rdback: assert property (p_rdback) else $error("colour readback wrong");
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   a_rdhold: assert property (p_rdhold) else $error("read data moved");
   a_hold: assert property (p_hold) else $error("output moved in stall");
   a_square: assert property (p_square) else $error("square flag wrong");
   a_step: assert property (p_step) else $error("pixel count jumped");
   a_line: assert property (p_line) else $error("line stepped mid line");
   a_max: assert property (p_max) else $error("count out of range");
   c_full: cover property (!pix_ready);
   c_stall: cover property (out_valid && !out_ready);
   c_sq: cover property (square_active);
   c_wrap: cover property ($changed(line_count));
endmodule

bind video_output_filter_colorspace vof_props u_props (
   .mclk(mclk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .pix_ready(pix_ready), .out_valid(out_valid), .out_ready(out_ready), .dac1(dac1),
   .chroma_out(chroma_out), .pix_count(pix_count), .line_count(line_count),
   .square_active(square_active)
);

// file: tb/pix_source.sv
`timescale 1ns/10ps
module pix_source (
   input wire logic          mclk,
   input wire logic          sys_rst,
   // Job
   input wire logic          go,
   input wire logic [15:0]   n,
   input wire vof_pkg::pix_t a,
   input wire vof_pkg::pix_t b,
   input wire vof_pkg::pix_t c,
   output logic [15:0]       sent,
   // Pixel port
   input wire logic          pix_ready,
   output logic              pix_valid,
   output vof_pkg::pix_t     pix_a,
   output vof_pkg::pix_t     pix_b,
   output vof_pkg::pix_t     pix_c
);
   import vof_pkg::*;
   logic [15:0] left_r;
   // One pixel per clock at most stands in for the source pixel clock
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         left_r <= 16'h0000;
         sent   <= 16'h0000;
      end else if (go) begin
         left_r <= n;
         sent   <= 16'h0000;
      end else if (pix_valid && pix_ready) begin
         left_r <= left_r - 16'h0001;
         sent   <= sent + 16'h0001;
      end
   end
   assign pix_valid = (left_r != 16'h0000);
   // Idle lines show garbage so stale data cannot pass unseen
   assign pix_a = pix_valid ? a : ~a;
   assign pix_b = pix_valid ? b : ~b;
   assign pix_c = pix_valid ? c : ~c;
endmodule

// file: tb/tb.sv
`timescale 1ns/10ps
module tb;
   import vof_pkg::*;
   typedef struct {logic [7:0] ad; logic [7:0] wd; logic [7:0] ex;} row_t;
   logic        mclk, sys_rst, reg_wr, reg_rd, out_ready, go, pix_valid, pix_ready;
   logic        out_valid, square_active;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, v;
   pix_t        pix_a, pix_b, pix_c, sa, sb, sc, dac1, dac2, dac3, chroma_out;
   logic [9:0]  pix_count, line_count;
   logic [15:0] n, sent;
   int          mismatches, n_tests, beats;
   row_t        rows [4] = '{'{8'h36, 8'hEB, 8'hEB}, '{8'h37, 8'h80, 8'h80},
                             '{8'h38, 8'h80, 8'h80}, '{8'h10, 8'h55, 8'h00}};
   video_output_filter_colorspace #(.FIFO_DEPTH(32)) uut (
      .mclk(mclk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_a(pix_a), .pix_b(pix_b),
      .pix_c(pix_c), .out_valid(out_valid), .out_ready(out_ready), .dac1(dac1),
      .dac2(dac2), .dac3(dac3), .luma_out(), .chroma_out(chroma_out),
      .composite_output(), .pix_count(pix_count), .line_count(line_count),
      .square_active(square_active));
   pix_source src (.mclk(mclk), .sys_rst(sys_rst), .go(go), .n(n), .a(sa), .b(sb), .c(sc),
      .sent(sent), .pix_ready(pix_ready), .pix_valid(pix_valid), .pix_a(pix_a),
      .pix_b(pix_b), .pix_c(pix_c));
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge mclk);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask
   task automatic start(input logic [15:0] cnt, input pix_t a, b, c);
      @(negedge mclk);
      n = cnt;
      sa = a;
      sb = b;
      sc = c;
      go = 1'b1;
      @(negedge mclk);
      go = 1'b0;
   endtask
   task automatic drain();
      for (int k = 0; k < 4000 && (pix_valid || out_valid); k++)
         @(negedge mclk);
      repeat (8) @(negedge mclk);
   endtask
   task automatic final_report();
      $display("Totals: %0d checks, %0d mismatches", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (out_valid && out_ready)
         beats++;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      final_report();
   end
   initial begin
      {sys_rst, reg_wr, reg_rd, go, out_ready} = 5'b10001;
      {reg_addr, reg_wdata, n, sa, sb, sc} = '0;
      repeat (3) @(negedge mclk);
      sys_rst = 1'b0;
      check("reset", {reg_rdata, chroma_out, out_valid, pix_ready, square_active,
                      pix_count, line_count}, {8'h00, 8'h80, 3'b010, 20'h0});
      $display("Test reset done");
      foreach (rows[i]) begin
         wr(rows[i].ad, rows[i].wd);
         rd(rows[i].ad, v);
         check("reg readback", v, rows[i].ex);
      end
      $display("Test registers done");
      wr(8'h82, 8'h10);
      check("square on", square_active, 1'b1);
      wr(8'h01, 8'h10);
      check("square in ED/HD", square_active, 1'b0);
      wr(8'h01, 8'h00);
      start(16'd790, 8'h80, 8'h80, 8'h80);
      drain();
      check("square counts", {pix_count, line_count}, {10'd10, 10'd1});
      wr(8'h82, 8'h00);
      start(16'd850, 8'h80, 8'h80, 8'h80);
      drain();
      check("normal counts", {pix_count, line_count}, {10'd2, 10'd2});
      $display("Test timing done");
      wr(8'h01, 8'h10);
      wr(8'h33, 8'h08);
      wr(8'h02, 8'h20);
      wr(8'h31, 8'h0C);
      start(16'd12, 8'h33, 8'h44, 8'h55);
      drain();
      check("pattern white", {dac1, dac2, dac3}, 24'hEB8080);
      wr(8'h31, 8'h00);
      start(16'd12, 8'h33, 8'h44, 8'h55);
      drain();
      check("external pass", {dac1, dac2, dac3}, 24'h334455);
      wr(8'h35, 8'h02);
      start(16'd12, 8'h33, 8'h44, 8'h55);
      drain();
      check("rgb stays rgb", {dac1, dac2, dac3}, 24'h334455);
      wr(8'h01, 8'h00);
      wr(8'h80, 8'h10);
      wr(8'h87, 8'h10);
      wr(8'hA2, 8'h0C);
      start(16'd12, 8'hC0, 8'h80, 8'h80);
      drain();
      check("gain clamp", {dac1, dac2, dac3}, 24'hFF8080);
      $display("Test colour done");
      out_ready = 1'b0;
      beats = 0;
      start(16'd40, 8'h21, 8'h43, 8'h65);
      repeat (60) @(negedge mclk);
      check("fifo refuses", pix_ready, 1'b0);
      check("fifo filled", sent >= 16'd32 && sent <= 16'd36, 1'b1);
      out_ready = 1'b1;
      drain();
      check("beats out", beats, 32'd40);
      $display("Test fifo done");
      final_report();
   end
endmodule
